// ---- hw/aev_consts.vh ----
// constants for the process alarm evaluator
`ifndef AEV_CONSTS_VH
`define AEV_CONSTS_VH

// clock and time base
`define AEV_CLK_PERIOD_NS   4
`define AEV_SEC_PERIOD_MS   1000
`define AEV_NS_PER_MS       1000000

// channel and output counts
`define AEV_NUM_ALARMS      3
`define AEV_NUM_AUX         3

// alarm type codes
`define AEV_T_OFF           5'h00
`define AEV_T_BAND_OUT      5'h01
`define AEV_T_DEV_HI        5'h02
`define AEV_T_DEV_LO        5'h03
`define AEV_T_BAND_IN       5'h04
`define AEV_T_BAND_OUT_SB   5'h05
`define AEV_T_DEV_HI_SB     5'h06
`define AEV_T_DEV_LO_SB     5'h07
`define AEV_T_ABS_HI        5'h08
`define AEV_T_ABS_LO        5'h09
`define AEV_T_ABS_HI_SB     5'h0A
`define AEV_T_ABS_LO_SB     5'h0B
`define AEV_T_LOOP_BREAK    5'h0C
`define AEV_T_RATE          5'h0D
`define AEV_T_SP_HI         5'h0E
`define AEV_T_SP_LO         5'h0F
`define AEV_T_MV_HI         5'h10
`define AEV_T_MV_LO         5'h11
`define AEV_T_MAX           5'h11
`define AEV_T_RESET         5'h02

// delays in seconds
`define AEV_DLY_MAX         10'h3E7

// global register offsets
`define AEV_REG_CTRL        8'h00
`define AEV_REG_ASSIGN      8'h01
`define AEV_REG_STATUS      8'h02

// per channel block: base is (channel + 1) in address bits 7:4
`define AEV_CH_TYPE         4'h0
`define AEV_CH_VALUE        4'h1
`define AEV_CH_LOWER        4'h2
`define AEV_CH_UPPER        4'h3
`define AEV_CH_HYST         4'h4
`define AEV_CH_ON_DLY       4'h5
`define AEV_CH_OFF_DLY      4'h6

// control register bits
`define AEV_CTRL_HEAT_COOL  0
`define AEV_CTRL_REARM      1

// output assignment codes, three bits per auxiliary output
`define AEV_ASN_OFF         3'h0
`define AEV_ASN_HEATER      3'h4
`define AEV_ASN_DEFAULT     3'h7
`define AEV_ASSIGN_RESET    9'h1D7

// reset values of the per channel settings
`define AEV_VALUE_RESET     16'h0000
`define AEV_HYST_RESET      16'h0002

`endif

// ---- hw/aev_sec_tick.v ----
// one second tick generator
`timescale 1ns/1ps
module aev_sec_tick #(
    parameter SEC_CYCLES = 250000000
) (
    input  wire        clock,
    input  wire        rstn,
    output reg         tick
);
    reg [27:0] count;

    // free running prescaler, one pulse per period
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count <= 28'h0000000;
            tick  <= 1'b0;
        end else if (count == SEC_CYCLES[27:0] - 28'h0000001) begin
            count <= 28'h0000000;
            tick  <= 1'b1;
        end else begin
            count <= count + 28'h0000001;
            tick  <= 1'b0;
        end
    end
endmodule // aev_sec_tick

// ---- hw/aev_delay.v ----
// on and off delay filter for one alarm channel
`timescale 1ns/1ps
module aev_delay (
    input  wire        clock,
    input  wire        rstn,
    input  wire        tick,
    input  wire        raw,
    input  wire [9:0]  on_delay,
    input  wire [9:0]  off_delay,
    output reg         state
);
    reg  [9:0] count;
    wire [9:0] limit = raw ? on_delay : off_delay;

    // state follows raw once more than limit ticks disagree, at once for a zero limit, so never early
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count <= 10'h000;
            state <= 1'b0;
        end else if (raw == state) begin
            count <= 10'h000;
        end else if ((limit == 10'h000) || (count > limit)) begin
            state <= raw;
            count <= 10'h000;
        end else if (tick) begin
            count <= count + 10'h001;
        end
    end
endmodule // aev_delay

// ---- hw/aev_evaluator.v ----
// process alarm evaluator: alarm channels, delays and output routing
//
// Behaviour
// - per channel type code, seventeen types plus off
// - type code resets to deviation upper limit
// - on and off delays up to 999 s
// - auxiliary outputs follow their assigned alarm
// - heater models: alarm 1 default heater, type hidden
// - type 1: alarm outside deviation band
// - type 2: alarm when above set point by X
// - type 3: alarm when below set point by X
// - type 4: alarm inside deviation band
// - band types keep separate lower and upper deviation
// - types 5 to 7 add standby to 1 to 3
// - type 5 off when hysteresis regions overlap
// - type 8: process value above X
// - type 9: process value below X
// - types 10, 11 add standby to 8, 9
// - loop break type only on alarm 1
// - type 13 takes external rate alarm
// - type 14: set point above X
// - type 15: set point below X
// - type 16: manipulated variable above X
// - type 17: manipulated variable below X
// - heat/cool: upper uses heating, lower cooling output
`timescale 1ns/1ps
`include "aev_consts.vh"
module aev_evaluator #(
    parameter SEC_CYCLES = `AEV_SEC_PERIOD_MS * (`AEV_NS_PER_MS / `AEV_CLK_PERIOD_NS)
) (
    input  wire        clock,
    input  wire        rstn,
    input  wire [7:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata,
    input  wire [15:0] process_value,
    input  wire [15:0] set_point,
    input  wire [15:0] manipulated_variable,
    input  wire [15:0] manipulated_variable_cool,
    input  wire        loop_break_alarm,
    input  wire [2:0]  rate_alarm,
    input  wire        heater_alarm,
    input  wire        heater_burnout_detect,
    input  wire        heater_short_detect,
    output reg  [2:0]  alarm_state,
    output reg  [2:0]  aux_out
);
    // settings per channel
    reg [4:0]  alm_type   [0:2];
    reg [15:0] alm_value  [0:2];
    reg [15:0] alm_lower  [0:2];
    reg [15:0] alm_upper  [0:2];
    reg [15:0] alm_hyst   [0:2];
    reg [9:0]  on_delay   [0:2];
    reg [9:0]  off_delay  [0:2];

    // global settings and state
    reg        heat_cool;
    reg [8:0]  assign_map;
    reg [15:0] prev_sp;
    reg [2:0]  cmp_state;
    reg [2:0]  standby;
    reg [2:0]  next_cmp;
    reg [2:0]  next_gated;
    reg [2:0]  next_rearm;
    wire [2:0] delayed;
    wire       sec_tick;

    // per channel scratch for the evaluation loop
    reg signed [17:0] dev;
    reg signed [17:0] xv;
    reg signed [17:0] lo_th;
    reg signed [17:0] hi_th;
    reg signed [17:0] hy;
    reg signed [17:0] mv_hi;
    reg signed [17:0] mv_lo;
    reg               sb_type;
    reg               on;
    integer           i, j, m, n;

    // decoded bus access
    wire [3:0] ch_sel   = addr[7:4];
    wire [3:0] ch_field = addr[3:0];
    wire       ch_hit   = (ch_sel != 4'h0) && (ch_sel <= 4'h3);
    wire [1:0] ch_idx   = ch_sel[1:0] - 2'h1;
    wire       fitted   = heater_burnout_detect | heater_short_detect;
    wire       alm1_used = (assign_map[2:0] == 3'h1) || (assign_map[5:3] == 3'h1) ||
                           (assign_map[8:6] == 3'h1);
    wire       type1_hidden = fitted && !alm1_used;

    // sign extend a 16 bit value into the comparison width
    function signed [17:0] sx;
        input [15:0] v;
        begin
            sx = {{2{v[15]}}, v};
        end
    endfunction

    // upper comparison: set at threshold, release at or below threshold minus hysteresis
    function hi_cmp;
        input signed [17:0] v;
        input signed [17:0] th;
        input signed [17:0] h;
        input               st;
        begin
            hi_cmp = st ? (v > th - h) : (v >= th);
        end
    endfunction

    // lower comparison: set at threshold, release at or above threshold plus hysteresis
    function lo_cmp;
        input signed [17:0] v;
        input signed [17:0] th;
        input signed [17:0] h;
        input               st;
        begin
            lo_cmp = st ? (v < th + h) : (v <= th);
        end
    endfunction

    // legality of a type code for a channel
    function type_ok;
        input [4:0] code;
        input [1:0] ch;
        begin
            type_ok = (code <= `AEV_T_MAX) &&
                      ((code != `AEV_T_LOOP_BREAK) || (ch == 2'h0));
        end
    endfunction

    // resolve an assignment field to an output level
    function route;
        input [2:0] code;
        input [2:0] alarms;
        input       fit;
        input       heat;
        begin
            case (code)
                3'h1:               route = alarms[0];
                3'h2:               route = alarms[1];
                3'h3:               route = alarms[2];
                `AEV_ASN_HEATER:    route = heat;
                `AEV_ASN_DEFAULT:   route = fit ? heat : alarms[0];
                default:            route = 1'b0;
            endcase
        end
    endfunction

    // second tick for the delay counters
    aev_sec_tick #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_tick (
        .clock (clock),
        .rstn  (rstn),
        .tick  (sec_tick)
    );

    // comparison of every channel against its type
    always @* begin
        next_cmp   = 3'h0;
        next_gated = 3'h0;
        dev   = sx(process_value) - sx(set_point);
        mv_hi = sx(manipulated_variable);
        mv_lo = heat_cool ? sx(manipulated_variable_cool) : sx(manipulated_variable);
        xv      = 18'sh00000;
        lo_th   = 18'sh00000;
        hi_th   = 18'sh00000;
        hy      = 18'sh00000;
        sb_type = 1'b0;
        on      = 1'b0;
        for (i = 0; i < `AEV_NUM_ALARMS; i = i + 1) begin
            xv    = sx(alm_value[i]);
            lo_th = -sx(alm_lower[i]);
            hi_th = sx(alm_upper[i]);
            hy    = {2'b00, alm_hyst[i]};
            on    = cmp_state[i];
            case (alm_type[i])
                `AEV_T_BAND_OUT, `AEV_T_BAND_OUT_SB:
                    next_cmp[i] = hi_cmp(dev, hi_th, hy, on) ||
                                  lo_cmp(dev, lo_th, hy, on);
                `AEV_T_DEV_HI, `AEV_T_DEV_HI_SB:
                    next_cmp[i] = hi_cmp(dev, xv, hy, on);
                `AEV_T_DEV_LO, `AEV_T_DEV_LO_SB:
                    next_cmp[i] = lo_cmp(dev, -xv, hy, on);
                `AEV_T_BAND_IN:
                    next_cmp[i] = on ? ((dev > lo_th - hy) && (dev < hi_th + hy)) :
                                       ((dev >= lo_th) && (dev <= hi_th));
                `AEV_T_ABS_HI, `AEV_T_ABS_HI_SB:
                    next_cmp[i] = hi_cmp(sx(process_value), xv + 18'sh00001, hy, on);
                `AEV_T_ABS_LO, `AEV_T_ABS_LO_SB:
                    next_cmp[i] = lo_cmp(sx(process_value), xv - 18'sh00001, hy, on);
                `AEV_T_LOOP_BREAK:
                    next_cmp[i] = (i == 0) ? loop_break_alarm : 1'b0;
                `AEV_T_RATE:
                    next_cmp[i] = rate_alarm[i];
                `AEV_T_SP_HI:
                    next_cmp[i] = hi_cmp(sx(set_point), xv + 18'sh00001, hy, on);
                `AEV_T_SP_LO:
                    next_cmp[i] = lo_cmp(sx(set_point), xv - 18'sh00001, hy, on);
                `AEV_T_MV_HI:
                    next_cmp[i] = hi_cmp(mv_hi, xv + 18'sh00001, hy, on);
                `AEV_T_MV_LO:
                    next_cmp[i] = lo_cmp(mv_lo, xv - 18'sh00001, hy, on);
                default:
                    next_cmp[i] = 1'b0;
            endcase
            // hysteresis overlap keeps the band with standby quiet
            if ((alm_type[i] == `AEV_T_BAND_OUT_SB) && (lo_th + hy >= hi_th - hy)) begin
                next_cmp[i] = 1'b0;
            end
            sb_type = (alm_type[i] == `AEV_T_BAND_OUT_SB) ||
                      (alm_type[i] == `AEV_T_DEV_HI_SB) ||
                      (alm_type[i] == `AEV_T_DEV_LO_SB) ||
                      (alm_type[i] == `AEV_T_ABS_HI_SB) ||
                      (alm_type[i] == `AEV_T_ABS_LO_SB);
            next_gated[i] = next_cmp[i] && !(sb_type && standby[i]);
        end
    end

    // events that restart the standby sequence
    always @* begin
        next_rearm = 3'h0;
        for (j = 0; j < `AEV_NUM_ALARMS; j = j + 1) begin
            next_rearm[j] = (set_point != prev_sp) ||
                            (wr && (addr == `AEV_REG_CTRL) && wdata[`AEV_CTRL_REARM]) ||
                            (wr && ch_hit && (ch_idx == j[1:0]) &&
                             (ch_field == `AEV_CH_TYPE));
        end
    end

    // comparator state, standby flags and set point history
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cmp_state <= 3'h0;
            standby   <= 3'h7;
            prev_sp   <= 16'h0000;
        end else begin
            cmp_state <= next_cmp;
            prev_sp   <= set_point;
            // a restart event wins over leaving standby in the same cycle
            standby   <= next_rearm | (standby & next_cmp);
        end
    end

    // on and off delays per channel
    genvar g;
    generate
        for (g = 0; g < `AEV_NUM_ALARMS; g = g + 1) begin : gen_dly
            aev_delay u_dly (
                .clock     (clock),
                .rstn      (rstn),
                .tick      (sec_tick),
                .raw       (next_gated[g]),
                .on_delay  (on_delay[g]),
                .off_delay (off_delay[g]),
                .state     (delayed[g])
            );
        end
    endgenerate

    // registered alarm and auxiliary outputs
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            alarm_state <= 3'h0;
            aux_out     <= 3'h0;
        end else begin
            alarm_state <= delayed;
            for (m = 0; m < `AEV_NUM_AUX; m = m + 1) begin
                aux_out[m] <= route(assign_map[3*m +: 3], delayed, fitted,
                                    heater_alarm);
            end
        end
    end

    // register writes
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            heat_cool  <= 1'b0;
            assign_map <= `AEV_ASSIGN_RESET;
            for (n = 0; n < `AEV_NUM_ALARMS; n = n + 1) begin
                alm_type[n]  <= `AEV_T_RESET;
                alm_value[n] <= `AEV_VALUE_RESET;
                alm_lower[n] <= `AEV_VALUE_RESET;
                alm_upper[n] <= `AEV_VALUE_RESET;
                alm_hyst[n]  <= `AEV_HYST_RESET;
                on_delay[n]  <= 10'h000;
                off_delay[n] <= 10'h000;
            end
        end else if (wr) begin
            if (addr == `AEV_REG_CTRL) begin
                heat_cool <= wdata[`AEV_CTRL_HEAT_COOL];
            end else if (addr == `AEV_REG_ASSIGN) begin
                assign_map <= wdata[8:0];
            end else if (ch_hit) begin
                case (ch_field)
                    `AEV_CH_TYPE: begin
                        if (type_ok(wdata[4:0], ch_idx) && (wdata[15:5] == 11'h000) &&
                            !((ch_idx == 2'h0) && type1_hidden)) begin
                            alm_type[ch_idx] <= wdata[4:0];
                        end
                    end
                    `AEV_CH_VALUE: alm_value[ch_idx] <= wdata;
                    `AEV_CH_LOWER: alm_lower[ch_idx] <= wdata;
                    `AEV_CH_UPPER: alm_upper[ch_idx] <= wdata;
                    `AEV_CH_HYST:  alm_hyst[ch_idx]  <= wdata;
                    `AEV_CH_ON_DLY: begin
                        if (wdata <= {6'h00, `AEV_DLY_MAX}) begin
                            on_delay[ch_idx] <= wdata[9:0];
                        end
                    end
                    `AEV_CH_OFF_DLY: begin
                        if (wdata <= {6'h00, `AEV_DLY_MAX}) begin
                            off_delay[ch_idx] <= wdata[9:0];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // register reads, data in the following cycle
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            if (addr == `AEV_REG_CTRL) begin
                rdata <= {15'h0000, heat_cool};
            end else if (addr == `AEV_REG_ASSIGN) begin
                rdata <= {7'h00, assign_map};
            end else if (addr == `AEV_REG_STATUS) begin
                rdata <= {2'h0, fitted, heater_alarm, standby, cmp_state, aux_out,
                          alarm_state};
            end else if (ch_hit) begin
                case (ch_field)
                    `AEV_CH_TYPE:
                        rdata <= ((ch_idx == 2'h0) && type1_hidden) ? 16'h0000 :
                                 {11'h000, alm_type[ch_idx]};
                    `AEV_CH_VALUE:   rdata <= alm_value[ch_idx];
                    `AEV_CH_LOWER:   rdata <= alm_lower[ch_idx];
                    `AEV_CH_UPPER:   rdata <= alm_upper[ch_idx];
                    `AEV_CH_HYST:    rdata <= alm_hyst[ch_idx];
                    `AEV_CH_ON_DLY:  rdata <= {6'h00, on_delay[ch_idx]};
                    `AEV_CH_OFF_DLY: rdata <= {6'h00, off_delay[ch_idx]};
                    default:         rdata <= 16'h0000;
                endcase
            end else begin
                rdata <= 16'h0000;
            end
        end else begin
            rdata <= 16'h0000;
        end
    end
endmodule // aev_evaluator

// ---- bench/aev_front.sv ----
// front end and control loop model feeding the evaluator
`timescale 1ns/1ps
module aev_front (
    input  logic        clock,
    input  logic        rstn,
    input  logic        slow,
    input  logic [15:0] pv_req,
    input  logic [15:0] sp_req,
    input  logic [15:0] mv_req,
    input  logic [15:0] mvc_req,
    output logic [15:0] process_value,
    output logic [15:0] set_point,
    output logic [15:0] manipulated_variable,
    output logic [15:0] manipulated_variable_cool
);
    logic [1:0] phase;

    // values follow each cycle, or only every fourth cycle when slow
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase <= 2'h0;
            {process_value, set_point} <= 32'h0;
            {manipulated_variable, manipulated_variable_cool} <= 32'h0;
        end else begin
            phase <= phase + 2'h1;
            if (!slow || phase == 2'h0) begin
                {process_value, set_point} <= {pv_req, sp_req};
                {manipulated_variable, manipulated_variable_cool} <= {mv_req, mvc_req};
            end
        end
    end
endmodule // aev_front

// ---- bench/aev_chk.sv ----
// assertions on the alarm evaluator ports
`timescale 1ns/1ps
module aev_chk (
    input logic        clock,
    input logic        rstn,
    input logic [7:0]  addr,
    input logic [15:0] wdata,
    input logic        wr,
    input logic        rd,
    input logic [15:0] rdata,
    input logic [15:0] process_value,
    input logic        heater_alarm,
    input logic        heater_burnout_detect,
    input logic        heater_short_detect,
    input logic [2:0]  alarm_state,
    input logic [2:0]  aux_out
);
    logic [8:0]  asn;
    logic [4:0]  typ2;
    logic [15:0] x2;
    logic [15:0] pv_q;
    logic [3:0]  asn_age;
    logic [3:0]  calm;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // mirrors of output assignment, channel 2 type and value, quiet time
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {asn, typ2, x2, pv_q} <= {9'h1D7, 5'h02, 32'h0};
            {asn_age, calm} <= 8'h00;
        end else begin
            pv_q <= process_value;
            asn_age <= (wr && addr == 8'h01) ? 4'h0 : asn_age + {3'h0, asn_age != 4'hF};
            calm <= (wr || process_value != pv_q) ? 4'h0 : calm + {3'h0, calm != 4'hF};
            if (wr && addr == 8'h01) asn <= wdata[8:0];
            if (wr && addr == 8'h20 && wdata < 16'h0012 && wdata != 16'h000C) typ2 <= wdata[4:0];
            if (wr && addr == 8'h21) x2 <= wdata;
        end
    end

    sequence s_status_rd;
        rd && addr == 8'h02;
    endsequence
    sequence s_ch2_abs;
        calm > 4'h4 && typ2 == 5'h08;
    endsequence

    property p_rd_quiet;
        !rd |=> rdata == 16'h0000;
    endproperty
    property p_status_alarm;
        s_status_rd |=> rdata[5:0] == {$past(aux_out), $past(alarm_state)};
    endproperty
    property p_status_heat;
        s_status_rd |=> rdata[13:12] ==
            {$past(heater_burnout_detect) | $past(heater_short_detect), $past(heater_alarm)};
    endproperty
    property p_reset_quiet;
        $rose(rstn) |-> alarm_state == 3'h0 && aux_out == 3'h0;
    endproperty
    property p_aux1_route;
        asn_age > 4'h1 && asn[5:3] inside {3'h1, 3'h2, 3'h3} |->
            aux_out[1] == alarm_state[asn[5:3] - 3'h1];
    endproperty
    property p_aux2_route;
        asn_age > 4'h1 && asn[8:6] inside {3'h1, 3'h2, 3'h3} |->
            aux_out[2] == alarm_state[asn[8:6] - 3'h1];
    endproperty
    property p_aux_off;
        asn_age > 4'h1 && asn[5:3] inside {3'h0, 3'h5, 3'h6} |-> !aux_out[1];
    endproperty
    property p_type_off;
        calm > 4'h3 && typ2 == 5'h00 |-> !alarm_state[1];
    endproperty
    property p_abs_on;
        s_ch2_abs ##0 $signed(process_value) > $signed(x2) |-> alarm_state[1];
    endproperty
    property p_abs_off;
        s_ch2_abs ##0 $signed(process_value) < $signed(x2) - 16'sd2 |-> !alarm_state[1];
    endproperty

    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
    a_status_alarm: assert property (p_status_alarm) else $error("status alarm bits");
    a_status_heat: assert property (p_status_heat) else $error("status heater bits");
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs after reset");
    a_aux1_route: assert property (p_aux1_route) else $error("aux1 routing");
    a_aux2_route: assert property (p_aux2_route) else $error("aux2 routing");
    a_aux_off: assert property (p_aux_off) else $error("aux1 not off");
    a_type_off: assert property (p_type_off) else $error("type off alarm on");
    a_abs_on: assert property (p_abs_on) else $error("absolute high missed");
    a_abs_off: assert property (p_abs_off) else $error("absolute high held");
endmodule // aev_chk

bind aev_evaluator aev_chk aev_chk_i (.clock, .rstn, .addr, .wdata, .wr, .rd, .rdata,
    .process_value, .heater_alarm, .heater_burnout_detect, .heater_short_detect,
    .alarm_state, .aux_out);

// ---- bench/aev_evaluator_bench.sv ----
// self-checking bench for the alarm evaluator
`timescale 1ns/1ps
`include "aev_consts.vh"
module aev_evaluator_bench;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        slow = 1'b0;
    logic        loop_break_alarm = 1'b0;
    logic        heater_alarm = 1'b0;
    logic        heater_burnout_detect = 1'b0;
    logic        heater_short_detect = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] pv_req = 16'h0000, sp_req = 16'h0000, mv_req = 16'h0000, mvc_req = 16'h0000;
    logic [15:0] rdata, process_value, set_point, manipulated_variable, manipulated_variable_cool;
    logic [2:0]  rate_alarm = 3'h0;
    logic [2:0]  alarm_state, aux_out;
    logic signed [15:0] x, l, h, p, s, m, c;
    logic [4:0]  t;
    logic [4:0]  tbl [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h08, 5'h09, 5'h0E,
                              5'h0F, 5'h10, 5'h11};
    bit          hc;
    integer      seed = 32'h292A, mismatches = 0, num_checks = 0, i, k;

    aev_evaluator #(.SEC_CYCLES(10)) aev_evaluator_i (.clock, .rstn, .addr, .wdata, .wr, .rd,
        .rdata, .process_value, .set_point, .manipulated_variable, .manipulated_variable_cool,
        .loop_break_alarm, .rate_alarm, .heater_alarm, .heater_burnout_detect,
        .heater_short_detect, .alarm_state, .aux_out);
    aev_front aev_front_i (.clock, .rstn, .slow, .pv_req, .sp_req, .mv_req, .mvc_req,
        .process_value, .set_point, .manipulated_variable, .manipulated_variable_cool);

    // clock at 250 MHz
    always #2 clock = ~clock;

    task results;
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task check(input string name, input [15:0] e, input [15:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask
    task wr_reg(input [7:0] a, input [15:0] d);
        @(posedge clock);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task pulse_rd(input [7:0] a);
        @(posedge clock);
        {addr, rd} <= {a, 1'b1};
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
    endtask
    task rd_chk(input [7:0] a, input [15:0] e);
        pulse_rd(a);
        check("rdata", e, rdata);
    endtask
    task settle;
        repeat (16) @(posedge clock);
        @(negedge clock);
    endtask
    task drive(input [15:0] pv, sp, mv, mvc);
        @(posedge clock);
        {pv_req, sp_req, mv_req, mvc_req} <= {pv, sp, mv, mvc};
        slow <= ~slow;
        settle;
    endtask
    // expected comparator outcome away from any threshold
    function automatic logic exp_alarm(input [4:0] ty, input bit hcm,
                                       input signed [15:0] pv, sp, mv, mvc, xv, lv, hv);
        case (ty)
            `AEV_T_BAND_OUT: return pv <= sp - lv || pv >= sp + hv;
            `AEV_T_DEV_HI: return pv - sp >= xv;
            `AEV_T_DEV_LO: return sp - pv >= xv;
            `AEV_T_BAND_IN: return pv > sp - lv && pv < sp + hv;
            `AEV_T_ABS_HI: return pv > xv;
            `AEV_T_ABS_LO: return pv < xv;
            `AEV_T_SP_HI: return sp > xv;
            `AEV_T_SP_LO: return sp < xv;
            `AEV_T_MV_HI: return mv > xv;
            `AEV_T_MV_LO: return (hcm ? mvc : mv) < xv;
            default: return 1'b0;
        endcase
    endfunction
    function automatic bit near(input signed [15:0] a, b);
        return a - b < 16'sd4 && b - a < 16'sd4;
    endfunction

    // watchdog
    initial begin
        repeat (8000) @(posedge clock);
        mismatches++;
        results;
    end

    // main sequence
    initial begin
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        for (k = 1; k < 4; k++) rd_chk(8'(16 * k), 16'h0002);
        rd_chk(8'h0F, 16'h0000);
        for (i = 0; i < 40; i++) begin
            t = tbl[{$random(seed)} % 11];
            x = $random(seed) % 64;
            l = {$random(seed)} % 64;
            h = {$random(seed)} % 64;
            hc = $random(seed);
            {p, s, m, c} = {16'($random(seed) % 200), 16'($random(seed) % 200),
                            16'($random(seed) % 200), 16'($random(seed) % 200)};
            wr_reg(8'h00, {15'h0, hc});
            wr_reg(8'h20, {11'h0, t});
            wr_reg(8'h21, x);
            wr_reg(8'h22, l);
            wr_reg(8'h23, h);
            drive(p, s, m, c);
            if (!(near(p, s + x) || near(p, s - x) || near(p, s - l) || near(p, s + h)
                  || near(p, x) || near(s, x) || near(m, x) || near(c, x)))
                check("alarm2", exp_alarm(t, hc, p, s, m, c, x, l, h), alarm_state[1]);
        end
        wr_reg(8'h00, 16'h0000);
        for (k = 0; k < 2; k++) begin
            drive(16'h0032, 0, 0, 0);
            wr_reg(8'h21, 16'h000A);
            wr_reg(8'h20, k ? 16'h000A : 16'h0006);
            settle;
            check("standby", 0, alarm_state[1]);
            drive(0, 0, 0, 0);
            drive(16'h0032, 0, 0, 0);
            check("armed", 1, alarm_state[1]);
            drive(16'h0032, 1, 0, 0);
            check("sp_moved", 0, alarm_state[1]);
        end
        wr_reg(8'h22, 16'h0032);
        wr_reg(8'h23, 16'h0032);
        wr_reg(8'h20, 16'h0005);
        drive(0, 0, 0, 0);
        drive(16'h0064, 0, 0, 0);
        check("band_sb", 1, alarm_state[1]);
        wr_reg(8'h22, 16'h0000);
        wr_reg(8'h23, 16'h0000);
        settle;
        check("overlap", 0, alarm_state[1]);
        wr_reg(8'h35, 16'h0002);
        wr_reg(8'h30, {11'h0, `AEV_T_ABS_HI});
        drive(-16'sd100, 0, 0, 0);
        drive(16'h0064, 0, 0, 0);
        check("on_early", 0, alarm_state[2]);
        repeat (24) @(posedge clock);
        @(negedge clock);
        check("on_late", 1, alarm_state[2]);
        wr_reg(8'h36, 16'h03E7);
        wr_reg(8'h36, 16'h03E8);
        rd_chk(8'h36, 16'h03E7);
        wr_reg(8'h10, 16'h000C);
        wr_reg(8'h20, 16'h000D);
        wr_reg(8'h20, 16'h000C);
        wr_reg(8'h20, 16'h0012);
        rd_chk(8'h20, 16'h000D);
        @(posedge clock);
        {loop_break_alarm, rate_alarm} <= 4'hA;
        settle;
        check("external", 16'h0003, {14'h0, alarm_state[1:0]});
        @(posedge clock);
        {heater_burnout_detect, heater_alarm} <= 2'h3;
        settle;
        check("aux0", 1, aux_out[0]);
        rd_chk(8'h10, 16'h0000);
        pulse_rd(8'h02);
        wr_reg(8'h01, 16'h00A9);
        rd_chk(8'h10, 16'h000C);
        wr_reg(8'h01, 16'h0008);
        settle;
        check("route", 16'h0002, {13'h0, aux_out});
        results;
    end
endmodule // aev_evaluator_bench
